// ---- spc_pkg.sv ----
// package for the sdram pin and command interface: command codes,
// power states, mode field positions and reset values.
// assumes a single rising-edge clock and a four-bank array.
package spc_pkg;

	// ----------------------------------------------------------------
	// array shape
	// ----------------------------------------------------------------
	localparam int ADDR_W = 13;
	localparam int BA_W   = 2;
	localparam int NBANK  = 4;

	// ----------------------------------------------------------------
	// address bit positions
	// ----------------------------------------------------------------
	localparam int PRECHARGE_FLAG_BIT = 10;
	localparam int COL_X4_HI_BIT      = 11;

	// ----------------------------------------------------------------
	// mode word fields and reset value (burst of one, latency two)
	// ----------------------------------------------------------------
	localparam int              MODE_BL_LSB = 0;
	localparam int              MODE_CL_LSB = 4;
	localparam logic [12:0]     MODE_RST    = 13'h0020;
	localparam logic [2:0]      BL_1        = 3'h0;
	localparam logic [2:0]      BL_2        = 3'h1;
	localparam logic [2:0]      BL_4        = 3'h2;
	localparam logic [2:0]      BL_8        = 3'h3;
	localparam logic [2:0]      BL_PAGE     = 3'h7;
	localparam logic [2:0]      CL_3        = 3'h3;
	localparam logic [1:0]      PWR_RST     = 2'h0;

	// ----------------------------------------------------------------
	// carriers and enumerations
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              cs_n;
		logic              ras_n;
		logic              cas_n;
		logic              we_n;
		logic [BA_W-1:0]   ba;
		logic [ADDR_W-1:0] addr;
	} spc_cmd_pins_s;

	// code is {ras_n, cas_n, we_n}, valid only with cs_n low
	typedef enum logic [2:0] {
		CMD_LMR = 3'b000,
		CMD_REF = 3'b001,
		CMD_PRE = 3'b010,
		CMD_ACT = 3'b011,
		CMD_WR  = 3'b100,
		CMD_RD  = 3'b101,
		CMD_BST = 3'b110,
		CMD_NOP = 3'b111
	} spc_cmd_e;

	typedef enum logic [1:0] {
		PS_RUN      = 2'b00,
		PS_PRE_PD   = 2'b01,
		PS_ACT_PD   = 2'b10,
		PS_SELF_REF = 2'b11
	} spc_pwr_e;

endpackage : spc_pkg

// ---- spc_sdram_pins.sv ----
// sdram pin-side command decoder, bank tracker, burst engine and data
// pins, with a small storage array standing in for the cell array.
// assumes pins are synchronous to clk_sys; dq is split into in/out/oe.
//
// Summary of operation
// - all inputs sampled on rising clock edge
// - clock steps burst counter and output registers
// - clock gate low: power-down, self refresh, suspend
// - clock gate answered directly while powered down
// - receivers ignored during power-down and self refresh
// - chip select low enables command decode
// - bursts and masks continue with chip select high
// - strobes plus chip select form command
// - masked write lanes leave storage unchanged
// - bank select picks target bank
// - activate takes thirteen-bit row
// - column bits depend on data width
// - flag bit requests auto precharge
// - precharge flag bit selects all banks
// - load mode takes address as opcode
// - data width four, eight or sixteen
// - burst lengths 1,2,4,8, page, terminate
`timescale 1ns/10ps
`default_nettype none

module spc_sdram_pins
	import spc_pkg::*;
#(
	parameter int DQ_W     = 16,
	parameter int ROW_KEEP = 1
) (
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	input  wire logic                  cke,
	input  wire spc_cmd_pins_s         pins,
	input  wire logic [((DQ_W > 8) ? 2 : 1)-1:0] dq_mask,
	input  wire logic [DQ_W-1:0]       dq_in,
	output logic      [DQ_W-1:0]       dq_out,
	output logic      [DQ_W-1:0]       dq_oe,
	output spc_pwr_e                   pwr_state,
	output logic                       clk_suspend,
	output logic                       rx_enable,
	output logic      [NBANK-1:0]      bank_open
);

	// ----------------------------------------------------------------
	// derived shape
	// ----------------------------------------------------------------
	localparam int MASK_W = (DQ_W > 8) ? 2 : 1;
	localparam int COL_W  = (DQ_W == 4) ? 11 : ((DQ_W == 8) ? 10 : 9);
	localparam int MEM_AW = BA_W + ROW_KEEP + COL_W;
	localparam int MEM_D  = 1 << MEM_AW;

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// column field; x16 drops bits 9 and 11, x8 drops bit 11
	function automatic logic [COL_W-1:0] col_of(input logic [ADDR_W-1:0] a);
		logic [10:0] c;
		c      = {a[COL_X4_HI_BIT], a[9:0]};
		col_of = c[COL_W-1:0];
	endfunction

	// spread byte masks over data bits
	function automatic logic [DQ_W-1:0] lanes(input logic [MASK_W-1:0] m);
		logic [DQ_W-1:0] r;
		r = '0;
		for (int i = 0; i < DQ_W; i++) begin
			r[i] = m[(MASK_W > 1) ? (i / 8) : 0];
		end
		lanes = r;
	endfunction

	// next column, wrapping inside the burst block
	function automatic logic [COL_W-1:0] col_next(input logic [COL_W-1:0] c,
		input logic [2:0] bl);
		logic [COL_W-1:0] w;
		logic [COL_W-1:0] inc;
		unique case (bl)
			BL_2:    w = {{(COL_W-1){1'b0}}, 1'b1};
			BL_4:    w = {{(COL_W-2){1'b0}}, 2'h3};
			BL_8:    w = {{(COL_W-3){1'b0}}, 3'h7};
			default: w = '1;
		endcase
		inc      = c + {{(COL_W-1){1'b0}}, 1'b1};
		col_next = (c & ~w) | (inc & w);
	endfunction

	// words per burst; page bursts never count down
	function automatic logic [3:0] bl_len(input logic [2:0] bl);
		unique case (bl)
			BL_2:    bl_len = 4'h2;
			BL_4:    bl_len = 4'h4;
			BL_8:    bl_len = 4'h8;
			default: bl_len = 4'h1;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	spc_pwr_e                pwr_q;
	logic [12:0]             mode_q;
	logic [NBANK-1:0]        open_q;
	logic [ADDR_W-1:0]       row_q [NBANK];
	logic                    burst_q;
	logic                    brd_q;
	logic                    page_q;
	logic                    ap_q;
	logic [BA_W-1:0]         bbank_q;
	logic [COL_W-1:0]        bcol_q;
	logic [3:0]              left_q;
	logic [DQ_W:0]           p0_q;
	logic [DQ_W:0]           p1_q;
	logic [MASK_W-1:0]       mask_q;
	logic                    out_v_q;
	logic [DQ_W-1:0]         dout_q;
	logic [DQ_W-1:0]         oe_q;
	logic [DQ_W-1:0]         mem [MEM_D];

	logic                    rx_on;
	logic                    hold;
	spc_cmd_e                cmd;
	logic [2:0]              bl;
	logic                    is_page;
	logic                    issue;
	logic                    stop;
	logic                    step;
	logic                    acc_v;
	logic                    acc_rd;
	logic [BA_W-1:0]         acc_bank;
	logic [COL_W-1:0]        acc_col;
	logic [MEM_AW-1:0]       idx;
	logic                    ap_close;
	logic [BA_W-1:0]         ap_bank;
	logic [DQ_W-1:0]         wmask;
	logic [DQ_W:0]           tap;

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	// receivers are off unless running with the clock gate high
	assign rx_on = (pwr_q == PS_RUN) && cke;
	// gate low mid-burst freezes the burst instead of powering down
	assign hold  = (pwr_q == PS_RUN) && !cke && burst_q;
	always_comb begin
		if (rx_on && !pins.cs_n) begin
			cmd = spc_cmd_e'({pins.ras_n, pins.cas_n, pins.we_n});
		end else begin
			cmd = CMD_NOP;
		end
	end

	assign bl      = mode_q[MODE_BL_LSB +: 3];
	assign is_page = (bl == BL_PAGE);
	assign issue   = (cmd == CMD_RD) || (cmd == CMD_WR);
	// terminate, or precharge hitting the burst bank, ends the burst
	assign stop    = (cmd == CMD_BST) || ((cmd == CMD_PRE) &&
		(pins.addr[PRECHARGE_FLAG_BIT] || (pins.ba == bbank_q)));
	// burst keeps going with chip select high
	assign step    = burst_q && !hold && !issue && !stop;

	// ----------------------------------------------------------------
	// access of this edge
	// ----------------------------------------------------------------
	always_comb begin
		acc_v    = issue || step;
		acc_rd   = issue ? (cmd == CMD_RD) : brd_q;
		acc_bank = issue ? pins.ba : bbank_q;
		acc_col  = issue ? col_of(pins.addr) : bcol_q;
	end
	// row comes from the bank opened earlier by the controller
	assign idx   = {acc_bank, row_q[acc_bank][ROW_KEEP-1:0], acc_col};
	assign wmask = lanes(dq_mask);

	// auto precharge closes the bank once the last word is done
	always_comb begin
		ap_close = 1'b0;
		ap_bank  = bbank_q;
		if (issue && pins.addr[PRECHARGE_FLAG_BIT] && !is_page &&
			(bl_len(bl) == 4'h1)) begin
			ap_close = 1'b1;
			ap_bank  = pins.ba;
		end else if (step && ap_q && !page_q && (left_q == 4'h1)) begin
			ap_close = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// storage; masked lanes keep their old bits
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (acc_v && !acc_rd) begin
			mem[idx] <= (mem[idx] & wmask) | (dq_in & ~wmask);
		end
	end

	// ----------------------------------------------------------------
	// power state
	// ----------------------------------------------------------------
	// exit follows the raw gate pin, not a registered copy of it
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pwr_q <= spc_pwr_e'(PWR_RST);
		end else begin
			unique case (pwr_q)
				PS_RUN: begin
					if (!cke && !burst_q) begin
						if (!pins.cs_n && ({pins.ras_n, pins.cas_n, pins.we_n} ==
							CMD_REF)) begin
							pwr_q <= PS_SELF_REF;
						end else if (|open_q) begin
							pwr_q <= PS_ACT_PD;
						end else begin
							pwr_q <= PS_PRE_PD;
						end
					end
				end
				PS_PRE_PD, PS_ACT_PD, PS_SELF_REF: begin
					if (cke) begin
						pwr_q <= PS_RUN;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// mode word
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mode_q <= MODE_RST;
		end else if (cmd == CMD_LMR) begin
			mode_q <= pins.addr;
		end
	end

	// ----------------------------------------------------------------
	// bank rows
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			open_q <= '0;
			for (int b = 0; b < NBANK; b++) begin
				row_q[b] <= '0;
			end
		end else begin
			if (ap_close) begin
				open_q[ap_bank] <= 1'b0;
			end
			if (cmd == CMD_PRE) begin
				if (pins.addr[PRECHARGE_FLAG_BIT]) begin
					open_q <= '0;
				end else begin
					open_q[pins.ba] <= 1'b0;
				end
			end
			if (cmd == CMD_ACT) begin
				open_q[pins.ba] <= 1'b1;
				row_q[pins.ba]  <= pins.addr;
			end
		end
	end

	// ----------------------------------------------------------------
	// burst engine
	// ----------------------------------------------------------------
	// clock steps the column counter except while suspended
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			burst_q <= 1'b0;
			brd_q   <= 1'b0;
			page_q  <= 1'b0;
			ap_q    <= 1'b0;
			bbank_q <= '0;
			bcol_q  <= '0;
			left_q  <= '0;
		end else if (issue) begin
			burst_q <= is_page || (bl_len(bl) != 4'h1);
			brd_q   <= (cmd == CMD_RD);
			page_q  <= is_page;
			ap_q    <= pins.addr[PRECHARGE_FLAG_BIT] && !is_page;
			bbank_q <= pins.ba;
			bcol_q  <= col_next(col_of(pins.addr), bl);
			left_q  <= bl_len(bl) - 4'h1;
		end else if (burst_q && !hold && stop) begin
			burst_q <= 1'b0;
		end else if (step) begin
			bcol_q <= col_next(bcol_q, bl);
			if (!page_q) begin
				left_q <= left_q - 4'h1;
				if (left_q == 4'h1) begin
					burst_q <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// read pipeline and output registers
	// ----------------------------------------------------------------
	// latency two taps the first stage, three the second
	assign tap = (mode_q[MODE_CL_LSB +: 3] == CL_3) ? p1_q : p0_q;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			p0_q    <= '0;
			p1_q    <= '0;
			out_v_q <= 1'b0;
			dout_q  <= '0;
		end else if (!hold) begin
			p0_q    <= {acc_v && acc_rd, mem[idx]};
			p1_q    <= p0_q;
			out_v_q <= tap[DQ_W];
			dout_q  <= tap[DQ_W-1:0];
		end
	end

	// mask is one edge old here, so the float lands two clocks after
	// it was sampled; it keeps working while suspended or deselected
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mask_q <= '0;
			oe_q   <= '0;
		end else begin
			mask_q <= dq_mask;
			oe_q   <= (hold ? {DQ_W{out_v_q}} : {DQ_W{tap[DQ_W]}}) &
				~lanes(mask_q);
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign dq_out      = dout_q;
	assign dq_oe       = oe_q;
	assign pwr_state   = pwr_q;
	assign clk_suspend = hold;
	assign rx_enable   = (pwr_q == PS_RUN);
	assign bank_open   = open_q;

endmodule // spc_sdram_pins

`default_nettype wire

// ---- spc_sdram_pins_properties.sv ----
// checker for the sdram pin interface: bank tracking, clock gate, masks.
// assumes it is bound into spc_sdram_pins and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module spc_sdram_pins_chk
	import spc_pkg::*;
#(
	parameter int DQ_W = 16
) (
	input wire logic             clk_sys,
	input wire logic             rst,
	input wire logic             cke,
	input wire spc_cmd_pins_s    pins,
	input wire logic [((DQ_W > 8) ? 2 : 1)-1:0] dq_mask,
	input wire logic [DQ_W-1:0]  dq_oe,
	input wire spc_pwr_e         pwr_state,
	input wire logic             clk_suspend,
	input wire logic [NBANK-1:0] bank_open
);
	// a command counts only when clocked, awake and selected
	logic       taken;
	logic [2:0] code;
	assign taken = cke && pwr_state == PS_RUN && !pins.cs_n;
	assign code  = {pins.ras_n, pins.cas_n, pins.we_n};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_act_opens_bank: assert property (taken && code == CMD_ACT |=> bank_open[$past(pins.ba)])
		else $error("activate left bank closed");
	a_pre_all_closes: assert property (taken && code == CMD_PRE && pins.addr[10] |=> !bank_open)
		else $error("precharge all left a bank open");
	a_pre_one_closes: assert property (taken && code == CMD_PRE |=> !bank_open[$past(pins.ba)])
		else $error("precharge left its bank open");
	// deselected edges may close banks by auto precharge but never open one
	a_deselect_ignored: assert property (pins.cs_n |=> !(bank_open & ~$past(bank_open)))
		else $error("deselected command opened a bank");
	a_idle_powers_down: assert property (!cke && pwr_state == PS_RUN && !bank_open
		&& !clk_suspend |=> pwr_state inside {PS_PRE_PD, PS_SELF_REF})
		else $error("idle device did not power down");
	a_open_row_pd: assert property (!cke && pwr_state == PS_RUN && |bank_open
		&& !clk_suspend |=> pwr_state == PS_ACT_PD)
		else $error("open row did not enter active power-down");
	a_wake_on_gate: assert property (pwr_state != PS_RUN && cke |=> pwr_state == PS_RUN)
		else $error("clock gate high did not wake device");
	a_mask_floats_low: assert property (dq_mask[0] |-> ##2 dq_oe[7:0] == 8'h00)
		else $error("lower mask did not float low byte");
	c_read: cover property (taken && code == CMD_RD);
	c_act_pd: cover property (pwr_state == PS_ACT_PD);
	c_load_mode: cover property (taken && code == CMD_LMR);
	c_suspend: cover property (clk_suspend);
endmodule // spc_sdram_pins_chk
bind spc_sdram_pins spc_sdram_pins_chk #(.DQ_W(DQ_W)) i_chk (.clk_sys(clk_sys), .rst(rst),
	.cke(cke), .pins(pins), .dq_mask(dq_mask), .dq_oe(dq_oe), .pwr_state(pwr_state),
	.clk_suspend(clk_suspend), .bank_open(bank_open));
`default_nettype wire

// ---- spc_ctrl_model.sv ----
// controller model: command pins, clock gate, masks and write data.
// assumes the device samples on rising edges; all changes land on falling ones.
`timescale 1ns/10ps
`default_nettype none
module spc_ctrl_model
	import spc_pkg::*;
(
	input  wire logic         clk_sys,
	output var spc_cmd_pins_s pins,
	output logic              cke,
	output logic [1:0]        dq_mask,
	output logic [15:0]       dq_in
);
	// idle deselected with the clock gate held on
	initial begin
		pins = '1;
		cke = 1'b1;
		dq_mask = 2'h0;
		dq_in = 16'h0;
	end
	// one command edge, then a nop edge that carries a second write word
	task automatic cmd(input logic cs_n, input spc_cmd_e c, input logic [1:0] ba,
		input logic [12:0] a, input logic [1:0] m, input logic [15:0] d0, input logic [15:0] d1);
		@(negedge clk_sys);
		pins = {cs_n, c, ba, a};
		dq_mask = m;
		dq_in = d0;
		@(negedge clk_sys);
		// bank and address are don't-care on a nop, so they wander
		pins = {1'b0, CMD_NOP, 2'($urandom), 13'($urandom)};
		dq_mask = 2'h0;
		dq_in = d1;
	endtask
	task automatic gate(input logic v);
		@(negedge clk_sys);
		cke = v;
	endtask
endmodule // spc_ctrl_model
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench: array model with banks, masks, bursts and clock gate.
// assumes the controller model issues every command on a falling edge.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import spc_pkg::*;
	logic          clk_sys;
	logic          rst;
	logic          cke;
	spc_cmd_pins_s pins;
	logic [1:0]    dq_mask;
	logic [15:0]   dq_in;
	logic [15:0]   dq_out;
	logic [15:0]   dq_oe;
	spc_pwr_e      pwr_state;
	logic          clk_suspend;
	logic          rx_enable;
	logic [3:0]    bank_open;
	int            mismatches;
	int            total_checks;
	int            cycles;
	int            col;
	int            k;
	logic [1:0]    m;
	logic [15:0]   d;
	int            c0;
	logic [15:0]   e;
	logic [15:0]   f;
	logic [15:0]   mem [int];
	spc_ctrl_model i_ctrl (.clk_sys(clk_sys), .pins(pins), .cke(cke), .dq_mask(dq_mask),
		.dq_in(dq_in));
	spc_sdram_pins #(.DQ_W(16), .ROW_KEEP(1)) i_dut (.clk_sys(clk_sys), .rst(rst), .cke(cke),
		.pins(pins), .dq_mask(dq_mask), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
		.pwr_state(pwr_state), .clk_suspend(clk_suspend), .rx_enable(rx_enable),
		.bank_open(bank_open));
	// 25 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		if (mismatches == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// access to bank 2, returning where the first word has settled
	task automatic op(input spc_cmd_e c, input int a, input logic [1:0] mk,
		input logic [15:0] d0);
		i_ctrl.cmd(1'b0, c, 2'h2, 13'(a), mk, d0, ~d0);
		@(negedge clk_sys);
	endtask
	// hang guard, far above the hundred or so cycles the run needs
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			report_and_stop();
		end
	end
	initial begin
		rst = 1'b1;
		void'($urandom(24815));
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'b0;
		check(pwr_state, PS_RUN);
		i_ctrl.cmd(1'b1, CMD_ACT, 2'h2, 13'h0, 2'h0, 16'h0, 16'h0);
		check(bank_open, 4'h0);
		i_ctrl.cmd(1'b0, CMD_ACT, 2'h2, 13'($urandom), 2'h0, 16'h0, 16'h0);
		check(bank_open, 4'h4);
		// full writes, each followed by a masked rewrite of the same column
		for (int i = 0; i < 6; i++) begin
			if (i % 2 == 0)
				col = $urandom & 32'h1bff;
			m = (i % 2) ? 2'((i + 1) / 2) : 2'h0;
			d = 16'($urandom);
			op(CMD_WR, col, m, d);
			k = col & 32'h1ff;
			if (m == 2'h0)
				mem[k] = d;
			else
				mem[k] = {m[1] ? mem[k][15:8] : d[15:8], m[0] ? mem[k][7:0] : d[7:0]};
		end
		foreach (mem[j]) begin
			op(CMD_RD, j, 2'h0, 16'h0);
			check(dq_out, mem[j]);
			check(dq_oe, 16'hffff);
			op(CMD_RD, j | 32'h0a00, 2'h2, 16'h0);
			check(dq_oe, 16'h00ff);
		end
		@(negedge clk_sys);
		check(dq_oe, 16'h0000);
		// burst of two from an odd column wraps inside its pair
		i_ctrl.cmd(1'b0, CMD_LMR, 2'h0, MODE_RST | 13'(BL_2), 2'h0, 16'h0, 16'h0);
		col = ($urandom & 32'h1ff) | 32'h1;
		d = 16'($urandom);
		op(CMD_WR, col, 2'h0, d);
		op(CMD_RD, col ^ 1, 2'h0, 16'h0);
		check(dq_out, ~d);
		@(negedge clk_sys);
		check(dq_out, d);
		i_ctrl.cmd(1'b0, CMD_ACT, 2'h0, 13'h0, 2'h0, 16'h0, 16'h0);
		i_ctrl.cmd(1'b0, CMD_PRE, 2'h2, 13'h0, 2'h0, 16'h0, 16'h0);
		check(bank_open, 4'h1);
		// auto-precharged pair, reopen, then a page read at latency three
		c0 = $urandom & 32'h1fc;
		e = 16'($urandom);
		f = 16'($urandom);
		i_ctrl.cmd(1'b0, CMD_WR, 2'h0, 13'(c0 | 32'h400), 2'h0, e, ~e);
		@(negedge clk_sys);
		check(bank_open, 4'h0);
		i_ctrl.cmd(1'b0, CMD_ACT, 2'h0, 13'h0, 2'h0, f, e);
		i_ctrl.cmd(1'b0, CMD_WR, 2'h0, 13'(c0 + 2), 2'h0, f, ~f);
		i_ctrl.cmd(1'b0, CMD_LMR, 2'h0, (13'(CL_3) << MODE_CL_LSB) | 13'(BL_PAGE),
			2'h0, e, f);
		i_ctrl.cmd(1'b0, CMD_RD, 2'h0, 13'(c0), 2'h0, f, e);
		// deselected stop is ignored, the burst and the mask go on
		i_ctrl.cmd(1'b1, CMD_BST, 2'h0, 13'h0, 2'h1, f, e);
		check(dq_out, e);
		check(dq_oe, 16'hffff);
		i_ctrl.gate(1'b0);
		check(dq_oe, 16'hff00);
		@(negedge clk_sys);
		check(clk_suspend, 1'b1);
		check(dq_out, ~e);
		check(pwr_state, PS_RUN);
		i_ctrl.gate(1'b1);
		@(negedge clk_sys);
		check(dq_out, f);
		i_ctrl.cmd(1'b0, CMD_BST, 2'h0, 13'h0, 2'h0, e, f);
		repeat (2) @(negedge clk_sys);
		check(dq_oe, 16'h0000);
		// clock gate low with a row open, then a refused precharge
		i_ctrl.gate(1'b0);
		@(negedge clk_sys);
		check(pwr_state, PS_ACT_PD);
		check(rx_enable, 1'b0);
		i_ctrl.cmd(1'b0, CMD_PRE, 2'h0, 13'h0400, 2'h0, 16'h0, 16'h0);
		check(bank_open, 4'h1);
		i_ctrl.gate(1'b1);
		@(negedge clk_sys);
		check(pwr_state, PS_RUN);
		i_ctrl.cmd(1'b0, CMD_PRE, 2'h3, 13'h0400, 2'h0, 16'h0, 16'h0);
		check(bank_open, 4'h0);
		i_ctrl.gate(1'b0);
		@(negedge clk_sys);
		check(pwr_state, PS_PRE_PD);
		i_ctrl.gate(1'b1);
		@(negedge clk_sys);
		check(pwr_state, PS_RUN);
		// refresh on the edge that drops the gate enters self refresh
		i_ctrl.pins = {1'b0, CMD_REF, 2'h0, 13'h0};
		i_ctrl.cke = 1'b0;
		@(negedge clk_sys);
		check(pwr_state, PS_SELF_REF);
		check(rx_enable, 1'b0);
		i_ctrl.gate(1'b1);
		@(negedge clk_sys);
		check(pwr_state, PS_RUN);
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
